/* File: design/rail_seq_params.svh */
// Offsets, reset values and timing counts of the rail sequencer
`ifndef RAIL_SEQ_PARAMS_SVH
`define RAIL_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)
`define RANGE_SW_US 320
`define WIDE_READ_US 53
`define NARROW_READ_US 70
`define US_CYCLES(t) (((t) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OFS_CTRL 12'h000
`define OFS_STATE 12'h004
`define OFS_MON_FLAG 12'h008
`define OFS_SEQ_FAULT 12'h00C
`define OFS_MEAS_CFG 12'h010
`define OFS_RAIL_BASE 12'h040
`define OFS_THR_BASE 12'h100
`define OFS_MEAS_BASE 12'h200

`define CTRL_IMM_BIT 4
`define CTRL_RST 5'h0F
`define MEAS_CFG_RST 15'h2822
`define ON_PRE_RST 16'h7310
`define OFF_PRE_RST 4'h0
`define GRP_RST 4'hF
`define TON_WAIT_RST 16'h0064
`define TON_TIMEOUT_RST 16'h00FA
`define TOFF_WAIT_RST 16'h0019
`define THR_HI_RST 12'hFFF
`define THR_LO_RST 12'h000

`define NUM_RAILS 4
`define NUM_CHAN 5
`define NUM_THR 30
`define NUM_MEAS 10
`endif

/* File: design/rail_seq_pkg.sv */
// Types shared by the rail sequencer and the measurement scheduler
package rail_seq_pkg;
	typedef enum logic [2:0] {
		RS_OFF, RS_WAIT_ON, RS_RAMP, RS_GOOD, RS_WAIT_OFF, RS_FAULT
	} rail_state_t;
	typedef enum logic [1:0] {SS_PICK, SS_CONV, SS_SWITCH} sched_state_t;
	typedef enum logic [1:0] {CT_NONE, CT_SENSE, CT_SHUNT} cur_type_t;
endpackage

/* File: design/meas_result_if.sv */
// Measurement result path from the scheduler to the monitor
`timescale 1ns/10ps
interface meas_result_if;
	logic valid;
	logic [2:0] chan;
	logic is_cur;
	logic [11:0] data;
	modport src(output valid, output chan, output is_cur, output data);
	modport snk(input valid, input chan, input is_cur, input data);
endinterface

/* File: design/meas_sched.sv */
// Round-robin scheduler for the shared 12-bit converter
`timescale 1ns/10ps
module meas_sched
	import rail_seq_pkg::*;
#(
	parameter int READ_WIDE = 5300,
	parameter int READ_NARROW = 7000,
	parameter int RANGE_SW = 32000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [14:0] meas_cfg_i,
	output logic adc_start_o,
	output logic [2:0] adc_chan_o,
	output logic adc_cur_o,
	output logic adc_diff_o,
	output logic adc_narrow_o,
	input wire logic adc_done_i,
	input wire logic [11:0] adc_data_i,
	meas_result_if.src res_o
);
	sched_state_t st_q;
	logic [4:0] step_q;
	logic [15:0] cnt_q;
	logic got_q;
	logic [11:0] data_q;

	// Steps 0-4 volts, 5-9 wide currents, 10 to narrow, 11-15, 16 back
	wire [2:0] ch = (step_q < 5'd5) ? step_q[2:0] :
		(step_q < 5'd10) ? 3'(step_q - 5'd5) : 3'(step_q - 5'd11);
	wire [1:0] ctype = meas_cfg_i[3 * ch + 1 +: 2];
	wire vdiff = meas_cfg_i[3 * ch];
	wire want_v = step_q < 5'd5;
	wire want_sa = step_q >= 5'd5 && step_q < 5'd10 &&
		ctype == CT_SENSE;
	wire want_sh = step_q >= 5'd11 && ctype == CT_SHUNT;
	wire is_sw = step_q == 5'd10 || step_q == 5'd16;
	wire any_shunt = meas_cfg_i[2:1] == CT_SHUNT ||
		meas_cfg_i[5:4] == CT_SHUNT || meas_cfg_i[8:7] == CT_SHUNT ||
		meas_cfg_i[11:10] == CT_SHUNT || meas_cfg_i[14:13] == CT_SHUNT;
	wire [4:0] step_nx = (step_q == 5'd16) ? 5'd0 : 5'(step_q + 5'd1);
	wire conv_end = st_q == SS_CONV && cnt_q == 16'h0000 &&
		(got_q || adc_done_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= SS_PICK;
			step_q <= 5'd0;
			cnt_q <= 16'h0000;
			got_q <= 1'b0;
			data_q <= 12'h000;
			adc_start_o <= 1'b0;
			adc_chan_o <= 3'd0;
			adc_cur_o <= 1'b0;
			adc_diff_o <= 1'b0;
			adc_narrow_o <= 1'b0;
		end else begin
			adc_start_o <= 1'b0;
			if (cnt_q != 16'h0000)
				cnt_q <= 16'(cnt_q - 16'h0001);
			case (st_q)
				SS_PICK: begin
					got_q <= 1'b0;
					if (is_sw && any_shunt) begin
						// Range change costs settle time
						adc_narrow_o <= (step_q == 5'd10);
						cnt_q <= 16'(RANGE_SW);
						st_q <= SS_SWITCH;
					end else if (want_v || want_sa || want_sh) begin
						adc_start_o <= 1'b1;
						adc_chan_o <= ch;
						adc_cur_o <= !want_v;
						adc_diff_o <= want_v ? vdiff : want_sh;
						cnt_q <= 16'(want_sh ? READ_NARROW : READ_WIDE);
						st_q <= SS_CONV;
					end else begin
						step_q <= step_nx;
					end
				end
				SS_SWITCH: if (cnt_q == 16'h0000) begin
					step_q <= step_nx;
					st_q <= SS_PICK;
				end
				SS_CONV: begin
					if (adc_done_i && !got_q) begin
						got_q <= 1'b1;
						data_q <= adc_data_i;
					end
					if (conv_end) begin
						step_q <= step_nx;
						st_q <= SS_PICK;
					end
				end
				default: st_q <= SS_PICK;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_o.valid <= 1'b0;
			res_o.chan <= 3'd0;
			res_o.is_cur <= 1'b0;
			res_o.data <= 12'h000;
		end else begin
			res_o.valid <= conv_end;
			if (conv_end) begin
				res_o.chan <= adc_chan_o;
				res_o.is_cur <= adc_cur_o;
				res_o.data <= got_q ? data_q : adc_data_i;
			end
		end
	end
endmodule

/* File: design/rail_sequencer_and_monitor.sv */
// Four-rail power sequencer with voltage and current monitor
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "rail_seq_params.svh"
module rail_sequencer_and_monitor
	import rail_seq_pkg::*;
#(
	parameter int TICK_CYCLES = `MS_CYCLES,
	parameter int READ_WIDE_CYCLES = `US_CYCLES(`WIDE_READ_US),
	parameter int READ_NARROW_CYCLES = `US_CYCLES(`NARROW_READ_US),
	parameter int RANGE_SW_CYCLES = `US_CYCLES(`RANGE_SW_US)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [3:0] rail_ok_signal_i,
	output logic [3:0] rail_en_o,
	output logic adc_start_o,
	output logic [2:0] adc_chan_o,
	output logic adc_cur_o,
	output logic adc_diff_o,
	output logic adc_narrow_o,
	input wire logic adc_done_i,
	input wire logic [11:0] adc_data_i
);
	// All rails named in mask show their bit set in vec
	function automatic logic all_met(input logic [3:0] mask,
		input logic [3:0] vec);
		all_met = &(vec | ~mask);
	endfunction

	function automatic logic [4:0] thr_idx(input logic [2:0] ch,
		input logic [2:0] k);
		thr_idx = 5'(ch) * 5'd6 + 5'(k);
	endfunction

	// Reset on-prereq nibble of rail r: chained bring-up
	function automatic logic [3:0] on_pre_rst(input int r);
		on_pre_rst = 4'(`ON_PRE_RST >> (4 * r));
	endfunction

	// Over limits reset wide open high, under limits low
	function automatic logic [11:0] thr_rst(input int t);
		thr_rst = (t % 6 == 2 || t % 6 == 3) ? `THR_LO_RST : `THR_HI_RST;
	endfunction

	// States in which a rail's converter is switched on
	function automatic logic drives_en(input rail_state_t s);
		drives_en = s == RS_RAMP || s == RS_GOOD || s == RS_WAIT_OFF;
	endfunction

	// Power-down may start once the off-prereqs are down
	function automatic logic off_go(input logic req_on,
		input logic [3:0] omask, input logic [3:0] dn);
		off_go = !req_on && all_met(omask, dn);
	endfunction

	// Immediate off skips the turn-off wait
	function automatic logic [15:0] toff_load(input logic imm,
		input logic [15:0] w);
		toff_load = imm ? 16'h0000 : w;
	endfunction

	meas_result_if res();

	logic ack_q;
	logic [31:0] dat_q;
	logic [3:0] on_q;
	logic imm_q;
	logic [14:0] meas_cfg_q;
	logic [11:0] mask_q [`NUM_RAILS];
	logic [15:0] tonw_q [`NUM_RAILS];
	logic [15:0] tonm_q [`NUM_RAILS];
	logic [15:0] toffw_q [`NUM_RAILS];
	logic [11:0] thr_q [`NUM_THR];
	logic [11:0] meas_q [`NUM_MEAS];
	logic [29:0] mon_q;
	logic [3:0] seq_fault_q;
	logic [4:0] vfault_q;
	rail_state_t st_q [`NUM_RAILS];
	rail_state_t st_d [`NUM_RAILS];
	logic [15:0] tmr_q [`NUM_RAILS];
	logic [15:0] tmr_d [`NUM_RAILS];
	logic [3:0] en_q;
	logic [16:0] tick_cnt_q;
	logic [3:0] kill;
	logic [3:0] down;
	logic [3:0] good;

	// Bus decode
	wire req = cyc_i & stb_i & ~ack_q;
	wire wr = req & we_i;
	wire [11:0] a = {adr_i[11:2], 2'b00};
	wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
		{8{sel_i[1]}}, {8{sel_i[0]}}};
	wire hit_ctrl = a == `OFS_CTRL;
	wire hit_state = a == `OFS_STATE;
	wire hit_mon = a == `OFS_MON_FLAG;
	wire hit_sfault = a == `OFS_SEQ_FAULT;
	wire hit_mcfg = a == `OFS_MEAS_CFG;
	wire hit_rail = a[11:6] == `OFS_RAIL_BASE >> 6;
	wire [1:0] ri = a[5:4];
	wire [1:0] rf = a[3:2];
	wire [5:0] ti = a[7:2];
	wire hit_thr = a[11:8] == `OFS_THR_BASE >> 8 && ti < 6'd30;
	wire [3:0] mi = a[5:2];
	wire hit_meas = a[11:6] == `OFS_MEAS_BASE >> 6 && mi < 4'd10;
	wire [31:0] rail_rd = (rf == 2'd0) ? {20'h0_0000, mask_q[ri]} :
		(rf == 2'd1) ? {16'h0000, tonw_q[ri]} :
		(rf == 2'd2) ? {16'h0000, tonm_q[ri]} : {16'h0000, toffw_q[ri]};
	wire [31:0] state_rd = {20'h0_0000, st_q[3], st_q[2], st_q[1],
		st_q[0]};
	// Unmapped space reads zero and ignores writes
	wire [31:0] rd_data =
		hit_ctrl ? {27'h000_0000, imm_q, on_q} :
		hit_state ? state_rd :
		hit_mon ? {2'b00, mon_q} :
		hit_sfault ? {28'h000_0000, seq_fault_q} :
		hit_mcfg ? {17'h0_0000, meas_cfg_q} :
		hit_rail ? rail_rd :
		hit_thr ? {20'h0_0000, thr_q[ti[4:0]]} :
		hit_meas ? {20'h0_0000, meas_q[mi]} : 32'h0000_0000;
	wire [31:0] wval = (rd_data & ~bmask) | (dat_i & bmask);
	wire [31:0] w1c = dat_i & bmask;

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req)
				dat_q <= rd_data;
		end
	end

	// Software configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{imm_q, on_q} <= `CTRL_RST;
			meas_cfg_q <= `MEAS_CFG_RST;
			for (int r = 0; r < `NUM_RAILS; r++) begin
				mask_q[r] <= {`GRP_RST, `OFF_PRE_RST, on_pre_rst(r)};
				tonw_q[r] <= `TON_WAIT_RST;
				tonm_q[r] <= `TON_TIMEOUT_RST;
				toffw_q[r] <= `TOFF_WAIT_RST;
			end
			for (int t = 0; t < `NUM_THR; t++)
				thr_q[t] <= thr_rst(t);
		end else if (wr) begin
			if (hit_ctrl)
				{imm_q, on_q} <= wval[`CTRL_IMM_BIT:0];
			if (hit_mcfg)
				meas_cfg_q <= wval[14:0];
			if (hit_rail) begin
				case (rf)
					2'd0: mask_q[ri] <= wval[11:0];
					2'd1: tonw_q[ri] <= wval[15:0];
					2'd2: tonm_q[ri] <= wval[15:0];
					default: toffw_q[ri] <= wval[15:0];
				endcase
			end
			if (hit_thr)
				thr_q[ti[4:0]] <= wval[11:0];
		end
	end

	// Measurement side
	meas_sched #(
		.READ_WIDE(READ_WIDE_CYCLES),
		.READ_NARROW(READ_NARROW_CYCLES),
		.RANGE_SW(RANGE_SW_CYCLES)
	) u_sched (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.meas_cfg_i(meas_cfg_q),
		.adc_start_o(adc_start_o),
		.adc_chan_o(adc_chan_o),
		.adc_cur_o(adc_cur_o),
		.adc_diff_o(adc_diff_o),
		.adc_narrow_o(adc_narrow_o),
		.adc_done_i(adc_done_i),
		.adc_data_i(adc_data_i),
		.res_o(res)
	);

	wire [4:0] tb = thr_idx(res.chan, 3'd0);
	wire is_v = res.valid & ~res.is_cur;
	wire is_c = res.valid & res.is_cur;
	wire ovf = is_v && res.data > thr_q[tb];
	wire ovw = is_v && res.data > thr_q[5'(tb + 5'd1)];
	wire uvw = is_v && res.data < thr_q[5'(tb + 5'd2)];
	wire uvf = is_v && res.data < thr_q[5'(tb + 5'd3)];
	wire ocw = is_c && res.data > thr_q[5'(tb + 5'd4)];
	wire ocf = is_c && res.data > thr_q[5'(tb + 5'd5)];
	// Flags sit six bits per channel
	wire [29:0] mon_set = {24'h00_0000, ocf, ocw, uvf, uvw, ovw, ovf}
		<< tb;
	wire [3:0] mi_w = 4'({res.chan, 1'b0} + {3'd0, res.is_cur});

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mon_q <= 30'h0000_0000;
			vfault_q <= 5'h00;
			for (int m = 0; m < `NUM_MEAS; m++)
				meas_q[m] <= 12'h000;
		end else begin
			// A new event outranks a clear in the same cycle
			mon_q <= (mon_q & ~((wr && hit_mon) ? w1c[29:0] :
				30'h0000_0000)) | mon_set;
			// Last reading per channel and kind
			if (res.valid)
				meas_q[mi_w] <= res.data;
			// Primary input bit has no rail to fault
			if (is_v)
				vfault_q[res.chan] <= ovf | uvf;
		end
	end

	// Sequencer
	// Coarse ms tick keeps every rail timer at 16 bits
	wire tick = tick_cnt_q == 17'(TICK_CYCLES - 1);

	// Group kill forces rails off at once, no turn-off wait

	always_comb begin
		for (int r = 0; r < `NUM_RAILS; r++) begin
			down[r] = st_q[r] == RS_OFF || st_q[r] == RS_FAULT;
			good[r] = st_q[r] == RS_GOOD;
			kill[r] = 1'b0;
			for (int f = 0; f < `NUM_RAILS; f++)
				if (f != r && st_q[f] == RS_FAULT && mask_q[f][8 + r])
					kill[r] = 1'b1;
		end
	end

	always_comb begin
		for (int r = 0; r < `NUM_RAILS; r++) begin
			st_d[r] = st_q[r];
			tmr_d[r] = (tick && tmr_q[r] != 16'h0000) ?
				16'(tmr_q[r] - 16'h0001) : tmr_q[r];
			case (st_q[r])
				RS_OFF: if (on_q[r] && !kill[r] &&
					all_met(mask_q[r][3:0], good)) begin
					st_d[r] = RS_WAIT_ON;
					tmr_d[r] = tonw_q[r];
				end
				// Prereqs lost while waiting abandon the attempt
				RS_WAIT_ON: if (!on_q[r] || kill[r] ||
					!all_met(mask_q[r][3:0], good)) begin
					st_d[r] = RS_OFF;
				end else if (tmr_q[r] == 16'h0000) begin
					st_d[r] = RS_RAMP;
					tmr_d[r] = tonm_q[r];
				end
				RS_RAMP: if (kill[r]) begin
					st_d[r] = RS_OFF;
				end else if (rail_ok_signal_i[r]) begin
					st_d[r] = RS_GOOD;
				end else if (tmr_q[r] == 16'h0000) begin
					st_d[r] = RS_FAULT;
					tmr_d[r] = toffw_q[r];
				end else if (off_go(on_q[r], mask_q[r][7:4], down)) begin
					st_d[r] = RS_WAIT_OFF;
					tmr_d[r] = toff_load(imm_q, toffw_q[r]);
				end
				RS_GOOD: if (!rail_ok_signal_i[r] || vfault_q[r]) begin
					st_d[r] = RS_FAULT;
					tmr_d[r] = toffw_q[r];
				end else if (kill[r]) begin
					st_d[r] = RS_OFF;
				end else if (off_go(on_q[r], mask_q[r][7:4], down)) begin
					st_d[r] = RS_WAIT_OFF;
					tmr_d[r] = toff_load(imm_q, toffw_q[r]);
				end
				RS_WAIT_OFF: if (tmr_q[r] == 16'h0000 || kill[r])
					st_d[r] = RS_OFF;
				RS_FAULT: if (tmr_q[r] == 16'h0000)
					st_d[r] = RS_OFF;
				default: st_d[r] = RS_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 17'h0_0000;
			en_q <= 4'h0;
			seq_fault_q <= 4'h0;
			for (int r = 0; r < `NUM_RAILS; r++) begin
				st_q[r] <= RS_OFF;
				tmr_q[r] <= 16'h0000;
			end
		end else begin
			tick_cnt_q <= tick ? 17'h0_0000 : 17'(tick_cnt_q + 17'h0_0001);
			for (int r = 0; r < `NUM_RAILS; r++) begin
				st_q[r] <= st_d[r];
				tmr_q[r] <= tmr_d[r];
				en_q[r] <= drives_en(st_d[r]);
				if (st_d[r] == RS_FAULT && st_q[r] != RS_FAULT)
					seq_fault_q[r] <= 1'b1;
				else if (wr && hit_sfault && w1c[r])
					seq_fault_q[r] <= 1'b0;
			end
		end
	end

	// Unregistered gate so a lost good signal drops enable at once for a rail in RS_GOOD
	assign rail_en_o = en_q & ~(good & ~rail_ok_signal_i);
endmodule

/* File: testbench/conv_model.sv */
// Behavioural power converters and shared measurement converter
`timescale 1ns/10ps
module conv_model #(
	parameter int RAMP = 20
) (
	input wire logic clk_i,
	input wire logic [3:0] en_i,
	input wire logic [3:0] block_i,
	output logic [3:0] ok_o,
	input wire logic start_i,
	input wire logic [2:0] chan_i,
	input wire logic cur_i,
	output logic done_o,
	output logic [11:0] data_o
);
	int ramp_q [4];
	int conv_q;
	initial begin
		ok_o = 4'h0;
		done_o = 1'b0;
		data_o = 12'h000;
		conv_q = 0;
		foreach (ramp_q[i])
			ramp_q[i] = 0;
	end
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			ramp_q[i] <= en_i[i] ? ramp_q[i] + 1 : 0;
			// Good pulled low once disabled; block holds a stuck ramp
			ok_o[i] <= en_i[i] && ramp_q[i] >= RAMP && !block_i[i];
		end
		conv_q <= start_i ? 3 : (conv_q != 0 ? conv_q - 1 : 0);
		done_o <= conv_q == 1;
		// Data only meaningful with done; toggles otherwise
		data_o <= conv_q == 1 ? {chan_i, cur_i, 8'h21} : ~data_o;
	end
endmodule

/* File: testbench/seq_chk.sv */
// Assertions on the ports of the rail sequencer
`timescale 1ns/10ps
module seq_chk #(
	parameter int TICK_CYCLES = 100000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic ack_o,
	input wire logic [3:0] rail_ok_signal_i,
	input wire logic [3:0] rail_en_o,
	input wire logic adc_start_o,
	input wire logic [2:0] adc_chan_o,
	input wire logic adc_cur_o,
	input wire logic adc_narrow_o
);
	// Tick granularity lets a wait end up to one tick early
	localparam int MIN_WAIT = 99 * TICK_CYCLES - 10;
	localparam int MAX_RAMP = 251 * TICK_CYCLES + 10;
	int run_q;
	int ramp_q;
	logic [3:0] up_q;
	wire [3:0] lost = up_q & ~rail_ok_signal_i;
	wire ramping = rail_en_o[3] & ~rail_ok_signal_i[3];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		run_q <= (rst_i || !rail_ok_signal_i[0]) ? 0 : run_q + 1;
		ramp_q <= (rst_i || !ramping) ? 0 : ramp_q + 1;
		up_q <= rst_i ? 4'h0 : rail_en_o & rail_ok_signal_i;
	end
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held for two cycles");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered");
	a_loss_drop: assert property (|lost |-> !(|(lost & rail_en_o)))
		else $error("enable kept after good was lost");
	a_prereq_two: assert property (
		$rose(rail_en_o[1]) |-> $past(rail_ok_signal_i[0]))
		else $error("rail two enabled before rail one good");
	a_prereq_four: assert property (
		$rose(rail_en_o[3]) |-> $past(&rail_ok_signal_i[2:0]))
		else $error("rail four enabled before its prerequisites");
	a_on_wait: assert property ($rose(rail_en_o[1]) |-> run_q >= MIN_WAIT)
		else $error("rail two enabled before its wait");
	a_ramp_limit: assert property (ramp_q <= MAX_RAMP)
		else $error("ramp kept past its timeout");
	a_adc_gap: assert property (adc_start_o |=> !adc_start_o [*3])
		else $error("conversion started too soon");
	a_volt_wide: assert property (adc_start_o && !adc_cur_o |-> !adc_narrow_o)
		else $error("voltage read in narrow range");
	a_skip_rail3: assert property (
		adc_start_o && adc_chan_o == 3'h2 |-> !adc_cur_o)
		else $error("current read on rail three");
	a_chan_five: assert property (adc_start_o |-> adc_chan_o <= 3'h4)
		else $error("channel out of range");
	c_rail4_on: cover property ($rose(rail_en_o[3]));
	c_shunt_read: cover property (adc_start_o && adc_narrow_o);
	c_bus_write: cover property (ack_o && we_i);
endmodule
bind rail_sequencer_and_monitor seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .ack_o(ack_o), .rail_ok_signal_i(rail_ok_signal_i),
	.rail_en_o(rail_en_o), .adc_start_o(adc_start_o),
	.adc_chan_o(adc_chan_o), .adc_cur_o(adc_cur_o),
	.adc_narrow_o(adc_narrow_o));

/* File: testbench/tb.sv */
// Self-checking bench for the rail sequencer and monitor
`timescale 1ns/10ps
module tb;
	localparam logic [4:0] ORD [9] = '{5'h00, 5'h04, 5'h08, 5'h0C,
		5'h10, 5'h02, 5'h12, 5'h07, 5'h0F};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [11:0] adr_i = 12'h000;
	logic [3:0] sel_i = 4'hF;
	logic [3:0] lanes = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o;
	logic [3:0] rail_ok_signal_i;
	logic [3:0] rail_en_o;
	logic [3:0] block_q = 4'h0;
	logic adc_start_o;
	logic [2:0] adc_chan_o;
	logic adc_cur_o;
	logic adc_diff_o;
	logic adc_narrow_o;
	logic adc_done_i;
	logic [11:0] adc_data_i;
	wire [4:0] slot = {adc_chan_o, adc_cur_o, adc_narrow_o};
	int err_count = 0;
	int checks = 0;
	always #5 clk_i = ~clk_i;
	rail_sequencer_and_monitor #(.TICK_CYCLES(10), .READ_WIDE_CYCLES(4),
		.READ_NARROW_CYCLES(5), .RANGE_SW_CYCLES(6)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .rail_ok_signal_i(rail_ok_signal_i),
		.rail_en_o(rail_en_o), .adc_start_o(adc_start_o),
		.adc_chan_o(adc_chan_o), .adc_cur_o(adc_cur_o),
		.adc_diff_o(adc_diff_o), .adc_narrow_o(adc_narrow_o),
		.adc_done_i(adc_done_i), .adc_data_i(adc_data_i));
	conv_model conv (.clk_i(clk_i), .en_i(rail_en_o), .block_i(block_q),
		.ok_o(rail_ok_signal_i), .start_i(adc_start_o),
		.chan_i(adc_chan_o), .cur_i(adc_cur_o), .done_o(adc_done_i),
		.data_o(adc_data_i));
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= lanes;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			err_count++;
			wrap_up();
		end
		@(posedge clk_i);
	endtask
	// Bit b of {good, enable}; counts edges until it reads v
	task automatic wfor(input int b, input logic v, input int lim,
		output int n);
		logic [7:0] s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			s = {rail_ok_signal_i, rail_en_o};
		end while (s[b] !== v && n < lim);
		if (s[b] !== v) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic wstart;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (adc_start_o !== 1'b1 && n < 200);
		if (adc_start_o !== 1'b1) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic t_regs;
		bus(1'b0, 12'h000, '0);
		chk(rd, 32'h0000_000F);
		bus(1'b0, 12'h010, '0);
		chk(rd, 32'h0000_2822);
		for (int r = 0; r < 4; r++) begin
			bus(1'b0, 12'h040 + 12'(r * 16), '0);
			chk(rd, 32'h0000_0F00 | ((32'h1 << r) - 1));
			bus(1'b0, 12'h044 + 12'(r * 16), '0);
			chk(rd, 32'h0000_0064);
			bus(1'b0, 12'h048 + 12'(r * 16), '0);
			chk(rd, 32'h0000_00FA);
			bus(1'b0, 12'h04C + 12'(r * 16), '0);
			chk(rd, 32'h0000_0019);
		end
		bus(1'b1, 12'h004, 32'hFFFF_FFFF);
		bus(1'b0, 12'h004, '0);
		chk(rd, 32'h0000_0001);
		bus(1'b1, 12'hFFC, 32'hFFFF_FFFF);
		bus(1'b0, 12'hFFC, '0);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_up;
		int n;
		wfor(4, 1'b1, 1500, n);
		wfor(1, 1'b1, 1200, n);
		chk(32'(n >= 985 && n <= 1010), 32'h1);
		chk(32'(rail_en_o[3:2]), 32'h0);
		wfor(7, 1'b1, 4000, n);
		bus(1'b0, 12'h004, '0);
		chk(rd, 32'h0000_06DB);
	endtask
	task automatic t_adc;
		int i;
		i = 0;
		do begin
			wstart();
			i++;
		end while (slot[4:1] !== 4'h0 && i < 20);
		for (int k = 0; k < 9; k++) begin
			if (k > 0)
				wstart();
			chk(32'(slot), 32'(ORD[k]));
			chk(32'(adc_diff_o), 32'(ORD[k][0]));
		end
		for (int c = 0; c < 10; c++) begin
			if (c == 5)
				continue;
			bus(1'b0, 12'h200 + 12'(c * 4), '0);
			chk(rd, 32'({3'(c / 2), 1'(c % 2), 8'h21}));
		end
	endtask
	task automatic t_thr;
		int i;
		bus(1'b1, 12'h108, 32'h0000_0030);
		lanes = 4'h2;
		// Only byte one lands, leaving the low byte of the reset value
		bus(1'b1, 12'h11C, 32'h1234_0056);
		lanes = 4'hF;
		bus(1'b0, 12'h11C, '0);
		chk(rd, 32'h0000_00FF);
		bus(1'b1, 12'h170, 32'h0000_0920);
		i = 0;
		do begin
			bus(1'b0, 12'h008, '0);
			i++;
		end while (rd !== 32'h1000_0084 && i < 100);
		chk(rd, 32'h1000_0084);
		bus(1'b1, 12'h108, 32'h0000_0000);
		bus(1'b1, 12'h11C, 32'h0000_0FFF);
		bus(1'b1, 12'h170, 32'h0000_0FFF);
		bus(1'b1, 12'h008, 32'hFFFF_FFFF);
		bus(1'b0, 12'h008, '0);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_loss;
		int n;
		block_q <= 4'h2;
		wfor(5, 1'b0, 20, n);
		chk(32'(rail_en_o[1]), 32'h0);
		wfor(3, 1'b0, 20, n);
		chk(32'(n <= 5 && rail_en_o === 4'h0), 32'h1);
		bus(1'b0, 12'h00C, '0);
		chk(rd, 32'h0000_0002);
		bus(1'b0, 12'h004, '0);
		chk(rd, 32'h0000_0028);
		block_q <= 4'h0;
		wfor(7, 1'b1, 6000, n);
		chk(32'(rail_ok_signal_i), 32'hF);
		bus(1'b1, 12'h00C, 32'hFFFF_FFFF);
		bus(1'b0, 12'h00C, '0);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_off;
		int n;
		bus(1'b1, 12'h000, 32'h0000_0007);
		wfor(3, 1'b0, 400, n);
		chk(32'(n >= 235 && n <= 265), 32'h1);
		chk(32'(rail_en_o), 32'h7);
	endtask
	task automatic t_tmo;
		int n;
		block_q <= 4'h8;
		bus(1'b1, 12'h000, 32'h0000_000F);
		wfor(3, 1'b1, 1200, n);
		wfor(3, 1'b0, 2600, n);
		chk(32'(n >= 2485 && n <= 2515), 32'h1);
		wfor(0, 1'b0, 5, n);
		chk(32'(rail_en_o), 32'h0);
		bus(1'b0, 12'h00C, '0);
		chk(rd, 32'h0000_0008);
		block_q <= 4'h0;
		wfor(7, 1'b1, 6000, n);
	endtask
	task automatic t_imm;
		int n;
		bus(1'b1, 12'h000, 32'h0000_0010);
		wfor(0, 1'b0, 10, n);
		chk(32'(rail_en_o), 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_up();
		t_adc();
		t_thr();
		t_loss();
		t_off();
		t_tmo();
		t_imm();
		wrap_up();
	end
endmodule
